// >>> design/channel_group_config_control.sv
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module channel_group_config_control
    import chgrp_pkg::*;
#(
    parameter int NUM_SLOTS    = 32,
    parameter int NUM_CHANNELS = 32
) (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic [3:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [3:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    frame_loss_condition,
    input  wire logic [NUM_SLOTS-1:0]    slot_tx_map_enable,
    input  wire logic [NUM_SLOTS-1:0]    slot_rx_map_enable,
    input  wire logic [NUM_CHANNELS-1:0] chan_rx_active,
    input  wire logic [NUM_CHANNELS-1:0] chan_transparent,
    input  wire logic                    tx_serial_data,
    output logic [NUM_SLOTS-1:0]         tx_slot_enable,
    output logic [NUM_SLOTS-1:0]         rx_slot_enable,
    output logic [NUM_SLOTS-1:0]         subchannel_allow,
    output logic [NUM_CHANNELS-1:0]      rx_chan_run,
    output logic [NUM_CHANNELS-1:0]      rx_msg_abort,
    output logic                         ext_buffer_space,
    output logic                         tx_data_out,
    output logic                         tx_data_oe
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb,
                                                input logic [31:0] mask);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r & mask;
    endfunction

    // Registers are whole words, so the two byte-lane address bits are dropped.
    function automatic logic [3:0] word_addr(input logic [3:0] addr);
        return {addr[3:2], 2'b00};
    endfunction

    // ****************************************************************
    // Register state
    // ****************************************************************

    logic [31:0]             group_control_q;
    logic [31:0]             memory_guard_descriptor_q;
    logic [NUM_CHANNELS-1:0] transp_deact_q;
    logic [NUM_CHANNELS-1:0] deact_clear;
    logic                    frame_loss_q;

    // ****************************************************************
    // Decoded group control
    // ****************************************************************
    logic rx_group_en;
    logic tx_group_en;
    logic sub_global_dis;
    logic loss_abort_mode;
    assign rx_group_en     = group_control_q[BIT_RX_GROUP_ENABLE];
    assign tx_group_en     = group_control_q[BIT_TRANSMIT_GROUP_ENABLE];
    assign sub_global_dis  = group_control_q[BIT_SUBCHANNEL_GLOBAL_DISABLE];
    assign loss_abort_mode = group_control_q[BIT_FRAME_LOSS_ABORT];

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    logic       aw_have_q;
    logic       w_have_q;
    logic [3:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic       write_fire;
    logic       aw_have_d;
    logic       w_have_d;
    logic       write_hit;

    assign write_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign aw_have_d  = write_fire ? 1'b0 : (aw_have_q | (s_axi_awvalid & s_axi_awready));
    assign w_have_d   = write_fire ? 1'b0 : (w_have_q | (s_axi_wvalid & s_axi_wready));

    always_comb begin
        if (aw_addr_q == ADDR_GROUP_CONTROL) begin
            write_hit = 1'b1;
        end else if (aw_addr_q == ADDR_GUARD_DESC) begin
            write_hit = 1'b1;
        end else if (aw_addr_q == ADDR_TRANSP_DEACT) begin
            write_hit = 1'b1;
        end else begin
            write_hit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            aw_addr_q     <= 4'h0;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
        end else begin
            aw_have_q     <= aw_have_d;
            w_have_q      <= w_have_d;
            s_axi_awready <= ~aw_have_d;
            s_axi_wready  <= ~w_have_d;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= word_addr(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // ****************************************************************
    // Write response
    // ****************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (write_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= write_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Register storage
    // ****************************************************************
    // Reserved bits are masked off, so they always hold and read zero.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            group_control_q           <= GROUP_CONTROL_RESET;
            memory_guard_descriptor_q <= GUARD_DESC_RESET;
        end else if (write_fire) begin
            if (aw_addr_q == ADDR_GROUP_CONTROL) begin
                group_control_q <= merge_bytes(group_control_q, w_data_q,
                                               w_strb_q, GROUP_CONTROL_MASK);
            end else if (aw_addr_q == ADDR_GUARD_DESC) begin
                // Stored only; no address is ever checked against it.
                memory_guard_descriptor_q <= merge_bytes(memory_guard_descriptor_q,
                                                         w_data_q, w_strb_q,
                                                         GUARD_DESC_MASK);
            end
        end
    end

    // ****************************************************************
    // Transparent reactivation
    // ****************************************************************
    // Writing one to a channel's bit reactivates it; zero bits leave it alone.
    logic [31:0] deact_word;
    assign deact_word = merge_bytes(32'h00000000, w_data_q, w_strb_q, 32'hffffffff);

    always_comb begin
        deact_clear = '0;
        if (write_fire && aw_addr_q == ADDR_TRANSP_DEACT) begin
            deact_clear = deact_word[NUM_CHANNELS-1:0];
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    logic        rvalid_d;
    logic [31:0] read_word;
    logic [1:0]  read_resp;
    logic [3:0]  rd_addr;

    assign rd_addr  = word_addr(s_axi_araddr);
    assign rvalid_d = s_axi_rvalid ? ~s_axi_rready : (s_axi_arvalid & s_axi_arready);

    always_comb begin
        read_word = 32'h00000000;
        read_resp = RESP_OKAY;
        if (rd_addr == ADDR_GROUP_CONTROL) begin
            read_word = group_control_q;
        end else if (rd_addr == ADDR_GUARD_DESC) begin
            read_word = memory_guard_descriptor_q;
        end else if (rd_addr == ADDR_STATUS) begin
            read_word[BIT_STAT_FRAME_LOSS] = frame_loss_q;
            read_word[BIT_STAT_EXT_BUFFER] = sub_global_dis;
        end else if (rd_addr == ADDR_TRANSP_DEACT) begin
            read_word[NUM_CHANNELS-1:0] = transp_deact_q;
        end else begin
            read_resp = RESP_SLVERR;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~rvalid_d;
            s_axi_rvalid  <= rvalid_d;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rdata <= read_word;
                s_axi_rresp <= read_resp;
            end
        end
    end

    // ****************************************************************
    // Frame loss input synchroniser
    // ****************************************************************
    // The state changes only when the second and third stages agree.
    logic [2:0] loss_sync_q;
    logic       loss_rise;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            loss_sync_q  <= 3'b000;
            frame_loss_q <= 1'b0;
        end else begin
            loss_sync_q <= {loss_sync_q[1:0], frame_loss_condition};
            if (loss_sync_q[1] == loss_sync_q[2]) begin
                frame_loss_q <= loss_sync_q[2];
            end
        end
    end

    assign loss_rise = (loss_sync_q[1] == loss_sync_q[2]) & loss_sync_q[2] & ~frame_loss_q;

    // ****************************************************************
    // Receive channel control
    // ****************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_msg_abort <= '0;
        end else if (loss_rise && loss_abort_mode) begin
            rx_msg_abort <= chan_rx_active;
        end else begin
            rx_msg_abort <= '0;
        end
    end

    // ****************************************************************
    // Transparent channel deactivation
    // ****************************************************************
    // A new deactivation wins over a host clear in the same cycle, so a
    // channel cannot slip back into service across a fresh frame loss.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            transp_deact_q <= '0;
        end else begin
            transp_deact_q <= (transp_deact_q & ~deact_clear)
                | ((loss_rise && loss_abort_mode) ? chan_transparent : '0);
        end
    end

    // HDLC channels are only held while the loss lasts and resume alone.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_chan_run <= '0;
        end else if (!rx_group_en) begin
            rx_chan_run <= '0;
        end else if (frame_loss_q && loss_abort_mode) begin
            rx_chan_run <= '0;
        end else begin
            rx_chan_run <= chan_rx_active & ~transp_deact_q;
        end
    end

    // ****************************************************************
    // Slot gating for transmit and receive
    // ****************************************************************
    // Gating acts on copies; the slot map inputs are never written.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_slot_enable <= '0;
            rx_slot_enable <= '0;
        end else begin
            tx_slot_enable <= tx_group_en ? slot_tx_map_enable : '0;
            rx_slot_enable <= rx_group_en ? slot_rx_map_enable : '0;
        end
    end

    // ****************************************************************
    // Subchannel override
    // ****************************************************************
    // The per-slot subchannel bits never reach this block: the global field overrides them all.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            subchannel_allow <= '0;
            ext_buffer_space <= 1'b0;
        end else begin
            subchannel_allow <= sub_global_dis ? '0 : '1;
            ext_buffer_space <= sub_global_dis;
        end
    end

    // ****************************************************************
    // Transmit pin
    // ****************************************************************
    // Only the group enable drives the three-state control; unmapped slots are the formatter's.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_data_out <= 1'b0;
            tx_data_oe  <= 1'b0;
        end else begin
            tx_data_out <= tx_serial_data;
            tx_data_oe  <= tx_group_en;
        end
    end

endmodule
`default_nettype wire

// >>> design/chgrp_pkg.sv
// Operation
// - Out-of-frame, handling disabled: abort all receive messages.
// - HDLC channels resume alone after out-of-frame clears.
// - Transparent channels deactivated; host reactivates them later.
// - Handling enabled: receive keeps processing during out-of-frame.
// - Global disable zero: subchanneling allowed in every slot.
// - Global disable one: subchanneling forbidden in every slot.
// - Global disable frees subchannel map as buffer space.
// - Transmit group off: slot enables cleared, data three-stated.
// - Transmit group on: mapped transmit slots may run.
// - Receive group off: all receive slot enables cleared.
// - Receive group on: mapped receive slots may run.
// - Group enables gate only; slot map bits untouched.
// - Guard descriptor holds high and low bound fields.
`default_nettype none
package chgrp_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [3:0] ADDR_GROUP_CONTROL  = 4'h0;
    localparam logic [3:0] ADDR_GUARD_DESC     = 4'h4;
    localparam logic [3:0] ADDR_STATUS         = 4'h8;
    localparam logic [3:0] ADDR_TRANSP_DEACT   = 4'hc;

    // ****************************************************************
    // Group control fields
    // ****************************************************************
    localparam int BIT_RX_GROUP_ENABLE          = 0;
    localparam int BIT_TRANSMIT_GROUP_ENABLE    = 1;
    localparam int BIT_SUBCHANNEL_GLOBAL_DISABLE = 2;
    localparam int BIT_FRAME_LOSS_ABORT         = 3;
    localparam logic [31:0] GROUP_CONTROL_MASK  = 32'h0000000f;
    localparam logic [31:0] GROUP_CONTROL_RESET = 32'h00000000;

    // ****************************************************************
    // Guard descriptor fields
    // ****************************************************************
    localparam int BIT_GUARD_ENABLE             = 31;
    localparam int GUARD_HIGH_LSB               = 16;
    localparam int GUARD_LOW_LSB                = 0;
    localparam int GUARD_BOUND_WIDTH            = 12;
    localparam logic [31:0] GUARD_DESC_MASK     = 32'h8fff0fff;
    localparam logic [31:0] GUARD_DESC_RESET    = 32'h00000000;

    // ****************************************************************
    // Status fields
    // ****************************************************************
    localparam int BIT_STAT_FRAME_LOSS          = 0;
    localparam int BIT_STAT_EXT_BUFFER          = 1;

    // ****************************************************************
    // Bus responses
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY            = 2'b00;
    localparam logic [1:0] RESP_SLVERR          = 2'b10;

endpackage
`default_nettype wire

// >>> verification/channel_group_config_control_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker
// ****************************************************************
module channel_group_config_control_assertions
    import chgrp_pkg::*;
#(
    parameter int NUM_SLOTS    = 32,
    parameter int NUM_CHANNELS = 32
) (
    input wire logic                    clk,
    input wire logic                    resetn,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic                    s_axi_rvalid,
    input wire logic [NUM_SLOTS-1:0]    slot_tx_map_enable,
    input wire logic [NUM_SLOTS-1:0]    slot_rx_map_enable,
    input wire logic [NUM_CHANNELS-1:0] chan_rx_active,
    input wire logic                    tx_serial_data,
    input wire logic [NUM_SLOTS-1:0]    tx_slot_enable,
    input wire logic [NUM_SLOTS-1:0]    rx_slot_enable,
    input wire logic [NUM_SLOTS-1:0]    subchannel_allow,
    input wire logic [NUM_CHANNELS-1:0] rx_chan_run,
    input wire logic [NUM_CHANNELS-1:0] rx_msg_abort,
    input wire logic                    ext_buffer_space,
    input wire logic                    tx_data_out,
    input wire logic                    tx_data_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_tx_gate_off: assert property (!tx_data_oe |-> tx_slot_enable == '0)
        else $error("transmit slots enabled while group is off");
    a_tx_slot_map: assert property (tx_data_oe |-> tx_slot_enable == $past(slot_tx_map_enable))
        else $error("transmit slot enables differ from the map");
    a_rx_slot_map: assert property ((rx_slot_enable & ~$past(slot_rx_map_enable)) == '0)
        else $error("receive slot enabled outside the map");
    a_subch_uniform: assert property (subchannel_allow == '0 || subchannel_allow == '1)
        else $error("subchannel allow differs between slots");
    a_ext_buffer: assert property (ext_buffer_space |-> subchannel_allow == '0)
        else $error("buffer space freed while subchanneling allowed");
    a_abort_pulse: assert property (rx_msg_abort != '0 |=> rx_msg_abort == '0)
        else $error("message abort longer than one cycle");
    a_run_subset: assert property ((rx_chan_run & ~$past(chan_rx_active)) == '0)
        else $error("idle channel marked as running");
    a_tx_data_delay: assert property (tx_data_oe |-> tx_data_out == $past(tx_serial_data))
        else $error("transmit data not the delayed input");
    a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
        else $error("read data not returned one cycle after address");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
endmodule

bind channel_group_config_control channel_group_config_control_assertions #(
    .NUM_SLOTS(NUM_SLOTS), .NUM_CHANNELS(NUM_CHANNELS)) chk_i (
    .clk(clk), .resetn(resetn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .slot_tx_map_enable(slot_tx_map_enable), .slot_rx_map_enable(slot_rx_map_enable),
    .chan_rx_active(chan_rx_active), .tx_serial_data(tx_serial_data),
    .tx_slot_enable(tx_slot_enable), .rx_slot_enable(rx_slot_enable),
    .subchannel_allow(subchannel_allow), .rx_chan_run(rx_chan_run),
    .rx_msg_abort(rx_msg_abort), .ext_buffer_space(ext_buffer_space),
    .tx_data_out(tx_data_out), .tx_data_oe(tx_data_oe));
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import chgrp_pkg::*;
;
    localparam logic [31:0] RXE = 32'h1 << BIT_RX_GROUP_ENABLE;
    localparam logic [31:0] TXE = 32'h1 << BIT_TRANSMIT_GROUP_ENABLE;
    localparam logic [31:0] SGD = 32'h1 << BIT_SUBCHANNEL_GLOBAL_DISABLE;
    localparam logic [31:0] FLA = 32'h1 << BIT_FRAME_LOSS_ABORT;
    logic        clk = 1'b0, resetn = 1'b0, frame_loss_condition = 1'b0, tx_serial_data = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, acc;
    logic [31:0] slot_tx_map_enable = 32'ha5a50f0f, slot_rx_map_enable = 32'h5a5af0f0;
    logic [31:0] chan_rx_active = 32'h000000ff, chan_transparent = 32'h000000f0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] tx_slot_enable, rx_slot_enable, subchannel_allow, rx_chan_run, rx_msg_abort;
    logic        ext_buffer_space, tx_data_out, tx_data_oe;
    int          n_errors = 0, check_count = 0, i;

    channel_group_config_control uut (.clk(clk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .frame_loss_condition(frame_loss_condition), .slot_tx_map_enable(slot_tx_map_enable),
        .slot_rx_map_enable(slot_rx_map_enable), .chan_rx_active(chan_rx_active),
        .chan_transparent(chan_transparent), .tx_serial_data(tx_serial_data),
        .tx_slot_enable(tx_slot_enable), .rx_slot_enable(rx_slot_enable),
        .subchannel_allow(subchannel_allow), .rx_chan_run(rx_chan_run),
        .rx_msg_abort(rx_msg_abort), .ext_buffer_space(ext_buffer_space),
        .tx_data_out(tx_data_out), .tx_data_oe(tx_data_oe));

    // ****************************************************************
    // Clock and stimulus helpers
    // ****************************************************************
    initial begin
        forever #20 clk = ~clk;
    end
    // A toggling transmit bit makes a stuck or undelayed data path visible.
    always @(posedge clk) begin
        tx_serial_data <= ~tx_serial_data;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic hung();
        n_errors++;
        $display("mismatch at %0t got %h exp %h", $time, 32'h0, 32'h1);
        stop_test();
    endtask
    // Each access starts after an edge, so a released strobe is never raised in the same step.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (k == 100) hung();
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a);
        int k;
        @(posedge clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (k == 100) hung();
        rd = s_axi_rdata; resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        cyc(16);
        resetn <= 1'b1;
        cyc(2);
        rdr(ADDR_GROUP_CONTROL); chk(rd, GROUP_CONTROL_RESET);
        chk({30'h0, resp}, {30'h0, RESP_OKAY});
        rdr(ADDR_GUARD_DESC); chk(rd, GUARD_DESC_RESET);
        // Status is read-only, so a write to it is refused.
        wr(ADDR_STATUS, 32'h0); chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        cyc(2); chk(tx_slot_enable, 32'h0); chk({31'h0, tx_data_oe}, 32'h0);
        chk(rx_slot_enable, 32'h0);
        $display("test reset done");
        // The host never sets the guard enable or any reserved bit.
        wr(ADDR_GUARD_DESC, 32'h0fff0fff); rdr(ADDR_GUARD_DESC); chk(rd, 32'h0fff0fff);
        wr(ADDR_GUARD_DESC, 32'h0abc0123); rdr(ADDR_GUARD_DESC); chk(rd, 32'h0abc0123);
        wr(ADDR_GUARD_DESC, 32'h0);
        $display("test guard done");
        wr(ADDR_GROUP_CONTROL, TXE); cyc(2); chk(tx_slot_enable, slot_tx_map_enable);
        chk({31'h0, tx_data_oe}, 32'h1); chk(rx_slot_enable, 32'h0);
        wr(ADDR_GROUP_CONTROL, RXE); cyc(2); chk(rx_slot_enable, slot_rx_map_enable);
        chk(tx_slot_enable, 32'h0);
        wr(ADDR_GROUP_CONTROL, TXE | RXE); cyc(2); chk(tx_slot_enable, 32'ha5a50f0f);
        rdr(ADDR_GROUP_CONTROL); chk(rd, TXE | RXE);
        $display("test gating done");
        wr(ADDR_GROUP_CONTROL, RXE | SGD); cyc(2); chk(subchannel_allow, 32'h0);
        chk({31'h0, ext_buffer_space}, 32'h1);
        wr(ADDR_GROUP_CONTROL, RXE | FLA); cyc(2); chk(subchannel_allow, 32'hffffffff);
        chk(rx_chan_run, 32'h000000ff);
        $display("test subchannel done");
        frame_loss_condition <= 1'b1;
        for (i = 0; i < 20 && rx_msg_abort === 32'h0; i++) @(posedge clk);
        if (i == 20) hung();
        chk(rx_msg_abort, chan_rx_active);
        cyc(2); chk(rx_chan_run, 32'h0);
        rdr(ADDR_STATUS); chk(rd, 32'h1);
        rdr(ADDR_TRANSP_DEACT); chk(rd, 32'h000000f0);
        frame_loss_condition <= 1'b0;
        cyc(8); chk(rx_chan_run, 32'h0000000f);
        wr(ADDR_TRANSP_DEACT, 32'h000000f0); cyc(3); chk(rx_chan_run, 32'h000000ff);
        rdr(ADDR_TRANSP_DEACT); chk(rd, 32'h0);
        wr(ADDR_GROUP_CONTROL, RXE);
        frame_loss_condition <= 1'b1;
        acc = 32'h0;
        repeat (12) begin
            @(posedge clk);
            acc = acc | rx_msg_abort;
        end
        chk(acc, 32'h0); chk(rx_chan_run, 32'h000000ff);
        frame_loss_condition <= 1'b0;
        $display("test frame loss done");
        stop_test();
    end
endmodule
`default_nettype wire
